// [byte_dma_pkg.sv]
// constants and types for the single-channel byte dma engine
// Contract
// - one byte moves per transaction; a message is one or more transactions
// - each transaction reads source into holding byte, then writes it to destination
// - buffer_pending_write is set from source read until destination write completes
// - reads reach flash, eeprom, sfr and ram; writes reach only sfr and ram
// - 22-bit source start and 16-bit destination start registers set message origins
// - running source and destination pointers update after every transaction
// - each pointer independently stays, increments or decrements by one
// - source and destination byte counts are independent of each other
// - counts support multi-byte sources such as two source, 2N destination
// - with channel priority the cpu is stalled until transfers finish
// - with cpu priority the channel only uses cycles the cpu leaves idle
package byte_dma_pkg;
    // ****************************************
    // register map (word offsets, byte addressed)
    // ****************************************
    localparam logic [3:0] ctrl0_idx = 4'h0;
    localparam logic [3:0] ctrl1_idx = 4'h1;
    localparam logic [3:0] src_start_idx = 4'h2;
    localparam logic [3:0] dst_start_idx = 4'h3;
    localparam logic [3:0] src_cnt_idx = 4'h4;
    localparam logic [3:0] dst_cnt_idx = 4'h5;
    localparam logic [3:0] src_ptr_idx = 4'h6;
    localparam logic [3:0] dst_ptr_idx = 4'h7;
    localparam logic [3:0] hold_idx = 4'h8;
    localparam logic [3:0] src_rem_idx = 4'h9;
    localparam logic [3:0] dst_rem_idx = 4'hA;
    // ****************************************
    // control 0 bit positions
    // ****************************************
    localparam int ctrl0_en_bit = 7;
    localparam int ctrl0_go_bit = 6;
    localparam int ctrl0_pri_bit = 5;
    localparam int ctrl0_xip_bit = 0;
    localparam int ctrl0_err_bit = 1;
    // ****************************************
    // control 1 fields
    // ****************************************
    localparam int ctrl1_dest_step_mode_lsb = 5;
    // kept clear of the source space field so eeprom stays readable
    localparam int ctrl1_dspace_bit = 7;
    localparam int ctrl1_source_step_mode_lsb = 1;
    localparam int ctrl1_sspace_lsb = 3;
    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int src_aw = 22;
    localparam int dst_aw = 16;
    localparam int cnt_w = 12;
    localparam logic [7:0] ctrl_rst = 8'h00;
    localparam logic [21:0] addr_rst = 22'h000000;
    localparam logic [11:0] cnt_rst = 12'h000;
    typedef enum logic [1:0] {
        step_hold = 2'b00,
        step_inc = 2'b01,
        step_dec = 2'b10
    } step_e;
    typedef enum logic [1:0] {
        space_data = 2'b00,
        space_flash = 2'b01,
        space_eeprom = 2'b10
    } space_e;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_read = 2'b01,
        st_write = 2'b10
    } dma_state_e;
endpackage : byte_dma_pkg

// [byte_dma_engine.sv]
// single-channel byte dma engine with avalon-mm register slave
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module byte_dma_engine (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_bus_busy,
    output logic cpu_stall,
    output logic mem_rd,
    output logic mem_wr,
    output logic [1:0] mem_space,
    output logic [byte_dma_pkg::src_aw-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic msg_done
);
    import byte_dma_pkg::*;

    logic [7:0] ctrl0_ff, nxt_ctrl0;
    logic [7:0] ctrl1_ff, nxt_ctrl1;
    logic [src_aw-1:0] src_start_ff, nxt_src_start;
    logic [dst_aw-1:0] dst_start_ff, nxt_dst_start;
    logic [cnt_w-1:0] src_cnt_ff, nxt_src_cnt;
    logic [cnt_w-1:0] dst_cnt_ff, nxt_dst_cnt;
    logic [src_aw-1:0] src_ptr_ff, nxt_src_ptr;
    logic [dst_aw-1:0] dst_ptr_ff, nxt_dst_ptr;
    logic [cnt_w-1:0] src_rem_ff, nxt_src_rem;
    logic [cnt_w-1:0] dst_rem_ff, nxt_dst_rem;
    logic [7:0] hold_ff, nxt_hold;
    logic xip_ff, nxt_xip;
    logic err_ff, nxt_err;
    logic done_ff, nxt_done;
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    dma_state_e state_ff, nxt_state;

    logic enabled, cpu_pri, may_use_bus, bus_req, err_set;
    logic [3:0] idx;
    step_e source_step_mode, dest_step_mode;
    logic [7:0] ctrl0_view;

    assign idx = avs_address[5:2];
    assign enabled = ctrl0_ff[ctrl0_en_bit];
    assign cpu_pri = ctrl0_ff[ctrl0_pri_bit];
    assign source_step_mode = step_e'(ctrl1_ff[ctrl1_source_step_mode_lsb +: 2]);
    assign dest_step_mode = step_e'(ctrl1_ff[ctrl1_dest_step_mode_lsb +: 2]);
    assign bus_req = avs_read | avs_write;
    // cpu priority: only idle bus cycles; channel priority: stall the cpu
    assign may_use_bus = cpu_pri ? ~cpu_bus_busy : 1'b1;
    assign cpu_stall = (state_ff != st_idle) && !cpu_pri;
    // one wait cycle keeps read data registered
    assign avs_waitrequest = bus_req & ~ack_ff;
    assign avs_readdata = rdata_ff;
    assign msg_done = done_ff;

    assign ctrl0_view = {ctrl0_ff[7:2], err_ff, xip_ff};

    function automatic logic [src_aw-1:0] step_src(input logic [src_aw-1:0] p, input step_e m);
        case (m)
            step_inc: step_src = p + 22'h000001;
            step_dec: step_src = p - 22'h000001;
            default: step_src = p;
        endcase
    endfunction : step_src

    function automatic logic [dst_aw-1:0] step_dst(input logic [dst_aw-1:0] p, input step_e m);
        case (m)
            step_inc: step_dst = p + 16'h0001;
            step_dec: step_dst = p - 16'h0001;
            default: step_dst = p;
        endcase
    endfunction : step_dst

    // ****************************************
    // memory port
    // ****************************************
    always_comb begin
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_space = space_data;
        mem_addr = src_ptr_ff;
        mem_wdata = hold_ff;
        if (clk_en && may_use_bus) begin
            if (state_ff == st_read) begin
                mem_rd = 1'b1;
                mem_space = ctrl1_ff[ctrl1_sspace_lsb +: 2];
            end else if (state_ff == st_write) begin
                mem_wr = 1'b1;
                mem_addr = {6'h00, dst_ptr_ff};
            end
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_ctrl0 = ctrl0_ff;
        nxt_ctrl1 = ctrl1_ff;
        nxt_src_start = src_start_ff;
        nxt_dst_start = dst_start_ff;
        nxt_src_cnt = src_cnt_ff;
        nxt_dst_cnt = dst_cnt_ff;
        nxt_src_ptr = src_ptr_ff;
        nxt_dst_ptr = dst_ptr_ff;
        nxt_src_rem = src_rem_ff;
        nxt_dst_rem = dst_rem_ff;
        nxt_hold = hold_ff;
        nxt_xip = xip_ff;
        nxt_err = err_ff;
        nxt_done = 1'b0;
        nxt_state = state_ff;
        err_set = 1'b0;

        case (state_ff)
            st_idle: begin
                if (enabled && ctrl0_ff[ctrl0_go_bit]) begin
                    if (ctrl1_ff[ctrl1_dspace_bit] || src_cnt_ff == cnt_rst
                        || dst_cnt_ff == cnt_rst) begin
                        // flash and eeprom are read-only targets
                        nxt_err = 1'b1;
                        err_set = 1'b1;
                        nxt_ctrl0[ctrl0_go_bit] = 1'b0;
                    end else if (xip_ff) begin
                        nxt_state = st_write;
                    end else begin
                        nxt_state = st_read;
                    end
                end
            end
            st_read: begin
                if (may_use_bus && !xip_ff) begin
                    nxt_hold = mem_rdata;
                    nxt_xip = 1'b1;
                    nxt_state = st_write;
                    if (src_rem_ff == 12'h001) begin
                        nxt_src_ptr = src_start_ff;
                        nxt_src_rem = src_cnt_ff;
                    end else begin
                        nxt_src_ptr = step_src(src_ptr_ff, source_step_mode);
                        nxt_src_rem = src_rem_ff - 12'h001;
                    end
                end
            end
            st_write: begin
                if (may_use_bus) begin
                    nxt_xip = 1'b0;
                    if (dst_rem_ff == 12'h001) begin
                        nxt_dst_ptr = dst_start_ff;
                        nxt_dst_rem = dst_cnt_ff;
                        nxt_ctrl0[ctrl0_go_bit] = 1'b0;
                        nxt_done = 1'b1;
                        nxt_state = st_idle;
                    end else begin
                        nxt_dst_ptr = step_dst(dst_ptr_ff, dest_step_mode);
                        nxt_dst_rem = dst_rem_ff - 12'h001;
                        nxt_state = (enabled && ctrl0_ff[ctrl0_go_bit]) ? st_read : st_idle;
                    end
                end
            end
            default: nxt_state = st_idle;
        endcase

        // ****************************************
        // register slave
        // ****************************************
        // writes land at the edge that ends the wait, as the master sees it
        if (avs_write && ack_ff) begin
            if (idx == ctrl0_idx) begin
                nxt_ctrl0 = {avs_writedata[7:2], 2'b00};
                // a fault raised in the same cycle outlives the clear
                if (avs_writedata[ctrl0_err_bit] && !err_set) begin
                    nxt_err = 1'b0;
                end
            end else if (idx == ctrl1_idx) begin
                nxt_ctrl1 = avs_writedata[7:0];
            end else if (idx == src_start_idx) begin
                nxt_src_start = avs_writedata[src_aw-1:0];
                nxt_src_ptr = avs_writedata[src_aw-1:0];
            end else if (idx == dst_start_idx) begin
                nxt_dst_start = avs_writedata[dst_aw-1:0];
                nxt_dst_ptr = avs_writedata[dst_aw-1:0];
            end else if (idx == src_cnt_idx) begin
                nxt_src_cnt = avs_writedata[cnt_w-1:0];
                nxt_src_rem = avs_writedata[cnt_w-1:0];
            end else if (idx == dst_cnt_idx) begin
                nxt_dst_cnt = avs_writedata[cnt_w-1:0];
                nxt_dst_rem = avs_writedata[cnt_w-1:0];
            end
        end
    end

    // ****************************************
    // register read answer
    // ****************************************
    always_comb begin
        nxt_ack = bus_req & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (avs_read && !ack_ff) begin
            if (idx == ctrl0_idx) begin
                nxt_rdata = {24'h000000, ctrl0_view};
            end else if (idx == ctrl1_idx) begin
                nxt_rdata = {24'h000000, ctrl1_ff};
            end else if (idx == src_start_idx) begin
                nxt_rdata = {10'h000, src_start_ff};
            end else if (idx == dst_start_idx) begin
                nxt_rdata = {16'h0000, dst_start_ff};
            end else if (idx == src_cnt_idx) begin
                nxt_rdata = {20'h00000, src_cnt_ff};
            end else if (idx == dst_cnt_idx) begin
                nxt_rdata = {20'h00000, dst_cnt_ff};
            end else if (idx == src_ptr_idx) begin
                nxt_rdata = {10'h000, src_ptr_ff};
            end else if (idx == dst_ptr_idx) begin
                nxt_rdata = {16'h0000, dst_ptr_ff};
            end else if (idx == hold_idx) begin
                nxt_rdata = {24'h000000, hold_ff};
            end else if (idx == src_rem_idx) begin
                nxt_rdata = {20'h00000, src_rem_ff};
            end else if (idx == dst_rem_idx) begin
                nxt_rdata = {20'h00000, dst_rem_ff};
            end else begin
                nxt_rdata = 32'h00000000;
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl0_ff <= ctrl_rst;
            ctrl1_ff <= ctrl_rst;
            src_start_ff <= addr_rst;
            dst_start_ff <= addr_rst[dst_aw-1:0];
            src_cnt_ff <= cnt_rst;
            dst_cnt_ff <= cnt_rst;
            err_ff <= 1'b0;
        end else if (clk_en) begin
            ctrl0_ff <= nxt_ctrl0;
            ctrl1_ff <= nxt_ctrl1;
            src_start_ff <= nxt_src_start;
            dst_start_ff <= nxt_dst_start;
            src_cnt_ff <= nxt_src_cnt;
            dst_cnt_ff <= nxt_dst_cnt;
            err_ff <= nxt_err;
        end
    end

    // ****************************************
    // running pointers and remaining counts
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            src_ptr_ff <= addr_rst;
            dst_ptr_ff <= addr_rst[dst_aw-1:0];
            src_rem_ff <= cnt_rst;
            dst_rem_ff <= cnt_rst;
        end else if (clk_en) begin
            src_ptr_ff <= nxt_src_ptr;
            dst_ptr_ff <= nxt_dst_ptr;
            src_rem_ff <= nxt_src_rem;
            dst_rem_ff <= nxt_dst_rem;
        end
    end

    // ****************************************
    // transaction state
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hold_ff <= 8'h00;
            xip_ff <= 1'b0;
            done_ff <= 1'b0;
            state_ff <= st_idle;
        end else if (clk_en) begin
            hold_ff <= nxt_hold;
            xip_ff <= nxt_xip;
            done_ff <= nxt_done;
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // register answer
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else if (clk_en) begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end
endmodule : byte_dma_engine

// [byte_dma_engine_props.sv]
// port checker for the byte dma engine
`timescale 1ns/1ns
module byte_dma_engine_props (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic cpu_bus_busy,
    input wire logic cpu_stall,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [byte_dma_pkg::src_aw-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic msg_done
);
    import byte_dma_pkg::*;
    logic pend_ff, nxt_pend;
    logic [7:0] cap_ff, nxt_cap;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ****************************************
    // byte held between source read and destination write
    // ****************************************
    always_comb begin
        nxt_pend = pend_ff;
        nxt_cap = cap_ff;
        if (clk_en && mem_rd) begin
            nxt_pend = 1'b1;
            nxt_cap = mem_rdata;
        end else if (clk_en && mem_wr) begin
            nxt_pend = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend_ff <= 1'b0;
            cap_ff <= 8'h00;
        end else begin
            pend_ff <= nxt_pend;
            cap_ff <= nxt_cap;
        end
    end
    a_one_strobe: assert property (!(mem_rd && mem_wr))
        else $error("read and write strobes together");
    a_write_after_read: assert property (mem_wr |-> pend_ff)
        else $error("write without a preceding read");
    a_no_reread: assert property (mem_rd |-> !pend_ff)
        else $error("read while a byte is pending");
    a_write_data_kept: assert property (mem_wr |-> mem_wdata == cap_ff)
        else $error("written byte differs from byte read");
    a_dest_in_data: assert property (mem_wr |-> mem_addr[21:16] == 6'h00)
        else $error("destination address wider than sixteen bits");
    a_cpu_first: assert property (cpu_bus_busy && !cpu_stall |-> !mem_rd && !mem_wr)
        else $error("channel used a busy cpu cycle");
    a_stall_moves: assert property (cpu_stall && clk_en |-> ##[0:2] (mem_rd || mem_wr || !cpu_stall))
        else $error("cpu stalled without channel progress");
    a_done_on_write: assert property (msg_done |-> $past(mem_wr))
        else $error("message end not after a write");
    a_done_pulse: assert property (msg_done |=> !msg_done)
        else $error("message end longer than one cycle");
    cover property (msg_done);
    cover property (cpu_stall && mem_rd);
    cover property (mem_wr && !cpu_stall);
endmodule : byte_dma_engine_props

bind byte_dma_engine byte_dma_engine_props chk (.mclk, .arst_n, .clk_en, .cpu_bus_busy,
    .cpu_stall, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .msg_done);

// [mem_bus_model.sv]
// memory bus and arbiter model facing the dma channel
`timescale 1ns/1ns
module mem_bus_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic busy_mode,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [1:0] mem_space,
    input wire logic [21:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic cpu_bus_busy
);
    logic [7:0] last_ff;
    logic [21:0] wr_addr [0:15];
    logic [7:0] wr_data [0:15];
    int n_wr;
    // an idle bus shows the inverse of the last byte, never a stale copy
    assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ {mem_space, 6'h15}) : ~last_ff;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            last_ff <= 8'h00;
            n_wr <= 0;
            cpu_bus_busy <= 1'b0;
        end else begin
            cpu_bus_busy <= busy_mode & ~cpu_bus_busy;
            if (mem_rd) begin
                last_ff <= mem_rdata;
            end
            if (mem_wr) begin
                wr_addr[n_wr[3:0]] <= mem_addr;
                wr_data[n_wr[3:0]] <= mem_wdata;
                n_wr <= n_wr + 1;
            end
        end
    end
endmodule : mem_bus_model

// [byte_dma_transaction_engine_bench.sv]
// testbench for the byte dma transaction engine
`timescale 1ns/1ns
module byte_dma_transaction_engine_bench;
    import byte_dma_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic busy_mode = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, cpu_bus_busy, cpu_stall, mem_rd, mem_wr, msg_done;
    logic [1:0] mem_space;
    logic [21:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata;
    int n_fail = 0;
    int compares = 0;
    int exp_wait = 2;
    always #25 mclk = ~mclk;
    byte_dma_engine uut (.mclk, .arst_n, .clk_en, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_bus_busy, .cpu_stall,
        .mem_rd, .mem_wr, .mem_space, .mem_addr, .mem_wdata, .mem_rdata, .msg_done);
    mem_bus_model mem (.mclk, .arst_n, .busy_mode, .mem_rd, .mem_wr, .mem_space,
        .mem_addr, .mem_wdata, .mem_rdata, .cpu_bus_busy);
    // ****************************************
    // shared bus and compare tasks
    // ****************************************
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
        int n;
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        chk("bus wait", exp_wait, n);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task run(input logic [7:0] c1, input logic [21:0] ss, input logic [15:0] ds,
        input logic [11:0] sc, input logic [11:0] dc, input logic pri, output int n0,
        output int st);
        int i;
        n0 = mem.n_wr;
        st = 0;
        bus(1'b1, ctrl1_idx, {24'h0, c1});
        bus(1'b1, src_start_idx, {10'h0, ss});
        bus(1'b1, dst_start_idx, {16'h0, ds});
        bus(1'b1, src_cnt_idx, {20'h0, sc});
        bus(1'b1, dst_cnt_idx, {20'h0, dc});
        bus(1'b1, ctrl0_idx, {24'h0, 2'b11, pri, 5'h00});
        i = 0;
        while (msg_done !== 1'b1 && i < 400) begin
            @(posedge mclk);
            i++;
            if (cpu_stall === 1'b1) begin
                st++;
            end
        end
        chk("message done", 1, i < 400);
    endtask : run
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        bus(1'b0, ctrl0_idx, 32'h0);
        chk("control 0 reset", 32'h0, q);
        bus(1'b0, ctrl1_idx, 32'h0);
        chk("control 1 reset", 32'h0, q);
        bus(1'b0, 4'hF, 32'h0);
        chk("unmapped read", 32'h0, q);
    endtask : t_reset
    task t_inc;
        int n0, k, st;
        run(8'h22, 22'h000040, 16'h0100, 12'h002, 12'h004, 1'b0, n0, st);
        chk("stall cycles", 8, st);
        chk("write count", 4, mem.n_wr - n0);
        for (k = 0; k < 4; k++) begin
            chk("dest addr", 32'h100 + k, mem.wr_addr[n0 + k]);
            chk("dest data", (8'h40 + k % 2) ^ 8'h15, mem.wr_data[n0 + k]);
        end
        bus(1'b0, ctrl0_idx, 32'h0);
        chk("pending flag", 0, q[ctrl0_xip_bit]);
    endtask : t_inc
    task t_dec;
        int n0, k, st;
        // cpu takes every other cycle, so the channel must fit into the gaps
        busy_mode <= 1'b1;
        run(8'h48, 22'h2ABCDE, 16'h0200, 12'h001, 12'h003, 1'b1, n0, st);
        busy_mode <= 1'b0;
        chk("stall cycles", 0, st);
        chk("write count", 3, mem.n_wr - n0);
        for (k = 0; k < 3; k++) begin
            chk("dest addr", 32'h200 - k, mem.wr_addr[n0 + k]);
            chk("dest data", 8'hDE ^ 8'h55, mem.wr_data[n0 + k]);
        end
    endtask : t_dec
    task t_refuse;
        int n0;
        n0 = mem.n_wr;
        bus(1'b1, ctrl1_idx, 32'h80);
        bus(1'b1, ctrl0_idx, 32'hC0);
        repeat (2) @(posedge mclk);
        bus(1'b0, ctrl0_idx, 32'h0);
        chk("refused flags", 32'h82, q);
        chk("refused writes", 0, mem.n_wr - n0);
        bus(1'b1, ctrl0_idx, 32'h82);
        bus(1'b0, ctrl0_idx, 32'h0);
        chk("error cleared", 32'h80, q);
    endtask : t_refuse
    task t_eeprom;
        int n0, k, st;
        run(8'h12, 22'h000010, 16'h0050, 12'h003, 12'h003, 1'b0, n0, st);
        chk("stall cycles", 6, st);
        for (k = 0; k < 3; k++) begin
            chk("dest addr", 32'h50, mem.wr_addr[n0 + k]);
            chk("dest data", (8'h10 + k) ^ 8'h95, mem.wr_data[n0 + k]);
        end
    endtask : t_eeprom
    task t_freeze;
        // four frozen edges delay the answer by four cycles
        exp_wait = 6;
        clk_en <= 1'b0;
        fork
            bus(1'b0, src_ptr_idx, 32'h0);
            begin
                repeat (4) @(posedge mclk);
                clk_en <= 1'b1;
            end
        join
        exp_wait = 2;
        chk("reloaded pointer", 32'h10, q);
    endtask : t_freeze
    task end_sim;
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_inc;
        t_dec;
        t_refuse;
        t_eeprom;
        t_freeze;
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        end_sim;
    end
endmodule : byte_dma_transaction_engine_bench
